/* hw/supervisor_core.sv */
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
// What this block does
// - Input clock loss switches CPU and peripherals onto the limp clock.
// - Entering limp mode latches a clock-loss NMI request.
// - Select bit: immediate reset, or NMI counter resets on overflow.
// - Clock loss also sets a readable missing-clock status bit.
// - 8-bit up counter; at maximum an active-low 512-cycle pulse.
// - Writing 0x55 then 0xAA to the key register clears the counter.
// - Expiry gives a device reset or a watchdog interrupt as configured.
// - Watchdog counter holds while the limp clock runs.
// - In STANDBY CPU, system and peripheral clocks stop; the watchdog runs and its interrupt can wake.
// - In IDLE the watchdog interrupt goes to the CPU via the expander.
// - In HALT the watchdog wakes the device by a device reset.
// - Mode 00 is IDLE; all clocks on; any recognized interrupt exits.
// - Mode 01 is STANDBY; CPU clocks off; reset, dog, GPIO, debugger exit.
// - Mode 1X is HALT; oscillator and PLL off; dog kept running.
// - Wake sources act low and must stay low through qualification.
// - Enabled port A lines wake STANDBY after programmed qualification.
// - Watchdog, reset pin and selected port A lines wake HALT.
// - HALT is entered only with the watchdog clock kept running.
// - Low power modes freeze every output pin in its current state.
// - Debug port stays clocked so the debugger can end STANDBY or HALT.
module supervisor_core (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic input_clock_lost_i,
  input wire logic [31:0] gpio_a_i,
  input wire logic external_reset_pin_n_i,
  input wire logic debug_wake_n_i,
  input wire logic idle_req_i,
  input wire logic cpu_irq_i,
  output logic limp_clock_sel_o,
  output logic nmi_o,
  output logic device_reset_o,
  output logic dog_reset_out_n_o,
  output logic dog_interrupt_n_o,
  output logic dog_irq_to_expander_o,
  output logic pin_hold_o,
  output logic low_power_o,
  output supervisor_pkg::clock_gate_t clock_gate_o
);

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  function automatic logic [7:0] prescale_mask(input logic [2:0] p);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (i < int'(p))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : prescale_mask

  // Pin synchronisers
  logic [34:0] raw;
  logic [34:0] s1_q;
  logic [34:0] s2_q;
  logic [34:0] s3_q;
  logic [34:0] stable_q;
  assign raw = {debug_wake_n_i, external_reset_pin_n_i, input_clock_lost_i, gpio_a_i};

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= `SYNC_RESET;
      s2_q <= `SYNC_RESET;
      s3_q <= `SYNC_RESET;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit moves only once the last two stages agree
  localparam logic [34:0] sync_init = `SYNC_RESET;
  genvar g;
  generate
    for (g = 0; g < 35; g++)
    begin : g_qual
      always_ff @(posedge ref_clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          stable_q[g] <= sync_init[g];
        end
        else if (s2_q[g] == s3_q[g])
        begin
          stable_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  logic [31:0] gpio_s;
  logic xrs_low;
  logic dbg_low;
  assign gpio_s = stable_q[31:0];
  assign xrs_low = ~stable_q[33];
  assign dbg_low = ~stable_q[34];

  // Registers
  supervisor_pkg::dog_ctrl_t ctrl_q;
  supervisor_pkg::lp_state_t lp_q;
  logic [1:0] mode_q;
  logic [7:0] qual_q;
  logic [31:0] wake_sel_q;
  logic [15:0] nmi_period_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic acc_wr;
  assign req = wb_cyc_i & wb_stb_i;
  // Writes land at the edge where the master sees ack
  assign acc_wr = req & ack_q & wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  logic [31:0] img_ctrl;
  logic [31:0] img_lpc;
  logic [31:0] new_ctrl;
  logic [31:0] new_lpc;
  logic [31:0] new_wake;
  logic [31:0] new_period;
  assign img_ctrl = {25'h0, ctrl_q};
  assign img_lpc = {16'h0, qual_q, 6'h0, mode_q};
  assign new_ctrl = lane_merge(img_ctrl, wb_dat_i, wb_sel_i);
  assign new_lpc = lane_merge(img_lpc, wb_dat_i, wb_sel_i);
  assign new_wake = lane_merge(wake_sel_q, wb_dat_i, wb_sel_i);
  assign new_period = lane_merge({16'h0, nmi_period_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `CTRL_RESET;
      mode_q <= `MODE_RESET;
      qual_q <= `QUAL_RESET;
      wake_sel_q <= `WAKE_SEL_RESET;
      nmi_period_q <= `NMI_PERIOD_RESET;
    end
    else if (acc_wr)
    begin
      case (wb_adr_i)
        `ADR_CTRL: ctrl_q <= new_ctrl[6:0];
        `ADR_LPC:
        begin
          mode_q <= new_lpc[`LPC_MODE_MSB:0];
          qual_q <= new_lpc[`LPC_QUAL_MSB:`LPC_QUAL_LSB];
        end
        `ADR_WAKE_SEL: wake_sel_q <= new_wake;
        `ADR_NMI_PERIOD: nmi_period_q <= new_period[15:0];
        default: ;
      endcase
    end
  end

  // Clock loss
  logic limp_q;
  logic loss_event;
  logic nmi_q;
  logic missing_q;
  logic [15:0] nmi_cnt_q;
  logic nmi_over;
  logic loss_reset;
  logic stat_wr;
  assign loss_event = stable_q[32] & ~limp_q;
  assign loss_reset = loss_event & ctrl_q.loss_reset_select;
  assign nmi_over = nmi_q & ~ctrl_q.loss_reset_select
    & (nmi_cnt_q == nmi_period_q);
  assign stat_wr = acc_wr & (wb_adr_i == `ADR_STATUS) & wb_sel_i[0];

  // Watchdog
  logic [7:0] pre_q;
  logic [7:0] dog_cnt_q;
  logic armed_q;
  logic dog_tick;
  logic dog_expire;
  logic key_wr;
  logic key_fire;
  logic [9:0] pulse_cnt_q;
  logic [9:0] pulse_cnt_d;
  logic pulse_rst_q;
  logic pulse_rst_d;
  logic pulse_dog_q;
  logic pulse_dog_d;
  logic reset_cause;
  logic int_cause;
  logic dog_int_flag_q;
  logic halt_dog_off;

  assign halt_dog_off = (lp_q == supervisor_pkg::LP_HALT) & ~ctrl_q.halt_dog_on;
  assign dog_tick = ctrl_q.enable & ~limp_q & ~halt_dog_off
    & (pulse_cnt_q == 10'h000)
    & (&(pre_q | ~prescale_mask(ctrl_q.prescale)));
  assign dog_expire = dog_tick & (dog_cnt_q == `DOG_MAX);
  assign key_wr = acc_wr & (wb_adr_i == `ADR_KEY) & wb_sel_i[0];
  assign key_fire = key_wr & armed_q & (wb_dat_i[7:0] == `KEY_FIRE);
  assign reset_cause = (dog_expire & ctrl_q.reset_mode) | loss_reset | nmi_over;
  assign int_cause = dog_expire & ~ctrl_q.reset_mode;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      limp_q <= 1'b0;
    end
    else
    begin
      limp_q <= stable_q[32];
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nmi_q <= 1'b0;
      missing_q <= 1'b0;
      dog_int_flag_q <= 1'b0;
    end
    else
    begin
      nmi_q <= loss_event
        | (nmi_q & ~(stat_wr & wb_dat_i[`STAT_NMI]) & ~reset_cause);
      missing_q <= loss_event | (missing_q & ~(stat_wr & wb_dat_i[`STAT_MISSING]));
      dog_int_flag_q <= int_cause | (dog_int_flag_q & ~(stat_wr & wb_dat_i[`STAT_DOG_INT]));
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nmi_cnt_q <= 16'h0000;
    end
    else if (reset_cause | ~nmi_q | ctrl_q.loss_reset_select)
    begin
      nmi_cnt_q <= 16'h0000;
    end
    else
    begin
      nmi_cnt_q <= nmi_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre_q <= 8'h00;
    end
    else
    begin
      pre_q <= pre_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      armed_q <= 1'b0;
    end
    else if (key_wr)
    begin
      armed_q <= (wb_dat_i[7:0] == `KEY_ARM);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dog_cnt_q <= 8'h00;
    end
    else if (reset_cause | key_fire)
    begin
      dog_cnt_q <= 8'h00;
    end
    else if (dog_tick)
    begin
      dog_cnt_q <= dog_cnt_q + 8'h01;
    end
  end

  // A reset cause always restarts the pulse, even over an interrupt pulse
  always_comb
  begin
    pulse_cnt_d = pulse_cnt_q;
    pulse_rst_d = pulse_rst_q;
    pulse_dog_d = pulse_dog_q;
    if (reset_cause)
    begin
      pulse_cnt_d = `PULSE_CYCLES;
      pulse_rst_d = 1'b1;
      pulse_dog_d = dog_expire;
    end
    else if (int_cause)
    begin
      pulse_cnt_d = `PULSE_CYCLES;
      pulse_rst_d = 1'b0;
      pulse_dog_d = 1'b1;
    end
    else if (pulse_cnt_q != 10'h000)
    begin
      pulse_cnt_d = pulse_cnt_q - 10'h001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pulse_cnt_q <= 10'h000;
      pulse_rst_q <= 1'b0;
      pulse_dog_q <= 1'b0;
      device_reset_o <= 1'b0;
      dog_reset_out_n_o <= 1'b1;
      dog_interrupt_n_o <= 1'b1;
    end
    else
    begin
      pulse_cnt_q <= pulse_cnt_d;
      pulse_rst_q <= pulse_rst_d;
      pulse_dog_q <= pulse_dog_d;
      device_reset_o <= (pulse_cnt_d != 10'h000) & pulse_rst_d;
      dog_reset_out_n_o <= ~((pulse_cnt_d != 10'h000) & pulse_rst_d & pulse_dog_d);
      dog_interrupt_n_o <= ~((pulse_cnt_d != 10'h000) & ~pulse_rst_d);
    end
  end

  // Low power controller
  logic [7:0] wq_cnt_q;
  logic wake_pins;
  logic wake_low;
  logic dog_int_low;
  assign dog_int_low = ~dog_interrupt_n_o;
  assign wake_pins = |(~gpio_s & wake_sel_q);
  always_comb
  begin
    wake_low = 1'b0;
    case (lp_q)
      supervisor_pkg::LP_STANDBY: wake_low = wake_pins | xrs_low | dbg_low
        | dog_int_low;
      supervisor_pkg::LP_HALT: wake_low = wake_pins | xrs_low | dbg_low;
      default: wake_low = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lp_q <= supervisor_pkg::LP_RUN;
      wq_cnt_q <= 8'h00;
    end
    else if (reset_cause)
    begin
      lp_q <= supervisor_pkg::LP_RUN;
      wq_cnt_q <= 8'h00;
    end
    else
    begin
      case (lp_q)
        supervisor_pkg::LP_RUN:
        begin
          wq_cnt_q <= 8'h00;
          if (idle_req_i)
          begin
            if (mode_q == 2'h0)
            begin
              lp_q <= supervisor_pkg::LP_IDLE;
            end
            else if (mode_q == 2'h1)
            begin
              lp_q <= supervisor_pkg::LP_STANDBY;
            end
            else if (ctrl_q.halt_dog_on & ctrl_q.enable)
            begin
              lp_q <= supervisor_pkg::LP_HALT;
            end
          end
        end
        supervisor_pkg::LP_IDLE:
        begin
          if (cpu_irq_i | xrs_low)
          begin
            lp_q <= supervisor_pkg::LP_RUN;
          end
        end
        supervisor_pkg::LP_STANDBY, supervisor_pkg::LP_HALT:
        begin
          // A glitch shorter than the qualification leaves the mode in place
          if (!wake_low)
          begin
            wq_cnt_q <= 8'h00;
          end
          else if (wq_cnt_q >= qual_q)
          begin
            lp_q <= supervisor_pkg::LP_RUN;
            wq_cnt_q <= 8'h00;
          end
          else
          begin
            wq_cnt_q <= wq_cnt_q + 8'h01;
          end
        end
        default: lp_q <= supervisor_pkg::LP_RUN;
      endcase
    end
  end

  // Outputs
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      limp_clock_sel_o <= 1'b0;
      nmi_o <= 1'b0;
      dog_irq_to_expander_o <= 1'b0;
      pin_hold_o <= 1'b0;
      low_power_o <= 1'b0;
      clock_gate_o <= '1;
    end
    else
    begin
      limp_clock_sel_o <= limp_q;
      nmi_o <= nmi_q;
      dog_irq_to_expander_o <= dog_int_low
        & ((lp_q == supervisor_pkg::LP_IDLE) | (lp_q == supervisor_pkg::LP_RUN));
      pin_hold_o <= (lp_q != supervisor_pkg::LP_RUN);
      low_power_o <= (lp_q != supervisor_pkg::LP_RUN);
      clock_gate_o.osc_pll <= (lp_q != supervisor_pkg::LP_HALT);
      clock_gate_o.cpu <= (lp_q == supervisor_pkg::LP_RUN)
        | (lp_q == supervisor_pkg::LP_IDLE);
      clock_gate_o.system <= (lp_q == supervisor_pkg::LP_RUN)
        | (lp_q == supervisor_pkg::LP_IDLE);
      clock_gate_o.periph <= (lp_q == supervisor_pkg::LP_RUN)
        | (lp_q == supervisor_pkg::LP_IDLE);
      clock_gate_o.dog <= ~halt_dog_off;
      clock_gate_o.debug <= 1'b1;
    end
  end

  // Bus slave: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q)
      begin
        case (wb_adr_i)
          `ADR_CTRL: rdata_q <= img_ctrl;
          `ADR_COUNT: rdata_q <= {24'h0, dog_cnt_q};
          `ADR_STATUS: rdata_q <= {27'h0, low_power_o, limp_q, dog_int_flag_q,
            nmi_q, missing_q};
          `ADR_LPC: rdata_q <= img_lpc;
          `ADR_WAKE_SEL: rdata_q <= wake_sel_q;
          `ADR_NMI_PERIOD: rdata_q <= {16'h0, nmi_period_q};
          `ADR_NMI_COUNT: rdata_q <= {16'h0, nmi_cnt_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : supervisor_core

/* inc/supervisor_cfg.svh */
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
// Register byte offsets
`define ADR_CTRL 8'h00
`define ADR_KEY 8'h04
`define ADR_COUNT 8'h08
`define ADR_STATUS 8'h0c
`define ADR_LPC 8'h10
`define ADR_WAKE_SEL 8'h14
`define ADR_NMI_PERIOD 8'h18
`define ADR_NMI_COUNT 8'h1c
// Status bit positions
`define STAT_MISSING 0
`define STAT_NMI 1
`define STAT_DOG_INT 2
`define STAT_LIMP 3
`define STAT_LOW_POWER 4
// Low power control field positions
`define LPC_MODE_MSB 1
`define LPC_QUAL_LSB 8
`define LPC_QUAL_MSB 15
// Key sequence and counter limits
`define KEY_ARM 8'h55
`define KEY_FIRE 8'haa
`define DOG_MAX 8'hff
`define PULSE_CYCLES 10'h200
// Reset values
`define CTRL_RESET 7'h0b
`define QUAL_RESET 8'h02
`define MODE_RESET 2'h0
`define WAKE_SEL_RESET 32'h0000_0000
`define NMI_PERIOD_RESET 16'h1000
`define SYNC_RESET 35'h6_ffff_ffff
`endif

/* inc/supervisor_pkg.sv */
package supervisor_pkg;
  typedef enum logic [1:0] {LP_RUN, LP_IDLE, LP_STANDBY, LP_HALT} lp_state_t;
  typedef struct packed {
    logic [2:0] prescale;
    logic halt_dog_on;
    logic loss_reset_select;
    logic reset_mode;
    logic enable;
  } dog_ctrl_t;
  typedef struct packed {
    logic osc_pll;
    logic cpu;
    logic system;
    logic periph;
    logic dog;
    logic debug;
  } clock_gate_t;
endpackage : supervisor_pkg

/* tb/supervisor_core_asserts.sv */
`timescale 1ns/1ps
module supervisor_core_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic input_clock_lost_i,
  input wire logic limp_clock_sel_o,
  input wire logic nmi_o,
  input wire logic device_reset_o,
  input wire logic dog_reset_out_n_o,
  input wire logic dog_interrupt_n_o,
  input wire logic dog_irq_to_expander_o,
  input wire logic pin_hold_o,
  input wire logic low_power_o,
  input wire supervisor_pkg::clock_gate_t clock_gate_o
);
  logic [9:0] low_cnt_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Length of the current dog pulse; pulses never overlap, so one counter serves both
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      low_cnt_q <= 10'h000;
    else if (!dog_reset_out_n_o || !dog_interrupt_n_o)
      low_cnt_q <= low_cnt_q + 10'h001;
    else
      low_cnt_q <= 10'h000;
  end
  a_reset_pulse_width: assert property (
    $rose(dog_reset_out_n_o) |-> low_cnt_q == 10'h200)
    else $error("dog reset pulse width wrong");
  a_int_pulse_width: assert property (
    $rose(dog_interrupt_n_o) |-> low_cnt_q == 10'h200)
    else $error("dog interrupt pulse width wrong");
  a_dog_resets_device: assert property (
    $fell(dog_reset_out_n_o) |-> ##[0:1] device_reset_o)
    else $error("dog expiry without device reset");
  a_int_not_reset: assert property (!dog_interrupt_n_o |-> dog_reset_out_n_o)
    else $error("dog interrupt and reset together");
  a_loss_sets_limp: assert property (input_clock_lost_i [*8] |-> limp_clock_sel_o)
    else $error("limp clock not selected on loss");
  a_limp_raises_nmi: assert property ($rose(limp_clock_sel_o) |-> ##[0:1] nmi_o)
    else $error("limp entry without nmi");
  a_pins_held: assert property (
    pin_hold_o == low_power_o && (pin_hold_o || clock_gate_o.cpu))
    else $error("pin hold differs from low power");
  a_debug_kept: assert property (
    !clock_gate_o.cpu |-> clock_gate_o.debug && low_power_o)
    else $error("debug clock stopped");
  a_halt_dog_on: assert property (
    !clock_gate_o.osc_pll |-> !clock_gate_o.cpu && clock_gate_o.dog)
    else $error("halt without dog clock");
  a_idle_expander: assert property (
    $fell(dog_interrupt_n_o) && clock_gate_o.cpu |-> ##[0:2] dog_irq_to_expander_o)
    else $error("dog interrupt not sent to expander");
endmodule : supervisor_core_asserts
bind supervisor_core supervisor_core_asserts supervisor_core_asserts_i (
  .ref_clk_i, .rst_i, .input_clock_lost_i, .limp_clock_sel_o, .nmi_o, .device_reset_o,
  .dog_reset_out_n_o, .dog_interrupt_n_o, .dog_irq_to_expander_o, .pin_hold_o,
  .low_power_o, .clock_gate_o
);

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAITC(c, n) for (int w = 0; w < (n) && !(c); w++) step(1);
module testbench;
  logic ref_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, input_clock_lost_i;
  logic external_reset_pin_n_i, debug_wake_n_i, idle_req_i, cpu_irq_i, go;
  logic limp_clock_sel_o, nmi_o, device_reset_o, dog_reset_out_n_o, dog_interrupt_n_o;
  logic dog_irq_to_expander_o, pin_hold_o, low_power_o;
  logic [7:0] wb_adr_i, hold;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, gpio_a_i, rv, c0;
  logic [4:0] line, sel_line;
  supervisor_pkg::clock_gate_t clock_gate_o;
  int bad_count, checked, n;
  logic [7:0] ra [7] = '{`ADR_CTRL, `ADR_KEY, `ADR_STATUS, `ADR_LPC, `ADR_WAKE_SEL,
    `ADR_NMI_PERIOD, 8'h20};
  logic [31:0] rx [7] = '{32'h0b, 32'h0, 32'h0, 32'h200, 32'h0, 32'h1000, 32'h0};
  logic [1:0] md [4] = '{2'b01, 2'b01, 2'b10, 2'b11};
  int src [4] = '{0, 3, 2, 0};
  supervisor_core supervisor_core_i (.ref_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .input_clock_lost_i, .gpio_a_i,
    .external_reset_pin_n_i, .debug_wake_n_i, .idle_req_i, .cpu_irq_i, .limp_clock_sel_o,
    .nmi_o, .device_reset_o, .dog_reset_out_n_o, .dog_interrupt_n_o, .dog_irq_to_expander_o,
    .pin_hold_o, .low_power_o, .clock_gate_o);
  wake_pin_model wake_pin_model_i (.ref_clk_i, .rst_i, .go_i(go), .line_i(line),
    .hold_i(hold), .gpio_a_o(gpio_a_i));
  function automatic supervisor_pkg::clock_gate_t gates(input logic [1:0] m);
    if (m == 2'b00)
      return 6'b111111;
    return (m == 2'b01) ? 6'b100011 : 6'b000011;
  endfunction : gates
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    #1;
    while (wb_ack_o !== 1'b1)
    begin
      step(1);
    end
    // Ack and read data stand until the next edge, where a write lands
    q = wb_dat_o;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    #1;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rv);
  endtask : wr
  task automatic sleep();
    idle_req_i <= 1'b1;
    step(1);
    idle_req_i <= 1'b0;
    step(2);
  endtask : sleep
  // Sources 0/1 are the selected and an unselected port line, 2 reset pin, 3 debugger
  task automatic pull(input int s, input int len);
    if (s < 2)
    begin
      line <= (s == 0) ? sel_line : sel_line + 5'd1;
      hold <= len[7:0];
      go <= 1'b1;
      step(1);
      go <= 1'b0;
      step(len + 8);
    end
    else
    begin
      external_reset_pin_n_i <= (s != 2);
      debug_wake_n_i <= (s != 3);
      step(len);
      external_reset_pin_n_i <= 1'b1;
      debug_wake_n_i <= 1'b1;
      // Let the pulse clear synchroniser and qualification before any check
      step(8);
    end
  endtask : pull
  task automatic close_out();
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    close_out();
  end
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, input_clock_lost_i, idle_req_i, cpu_irq_i, go} = 7'h00;
    {rst_i, external_reset_pin_n_i, debug_wake_n_i} = 3'h7;
    {wb_adr_i, wb_sel_i, wb_dat_i, line, hold} = 57'h0;
    bad_count = 0;
    checked = 0;
    rv = $urandom(32'h9e3e);
    sel_line = 5'($urandom % 31);
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wr(8'h20, $urandom);
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, ra[i], 32'h0, rv);
      `CHK(rv, rx[i])
    end
    // Slow prescale so the key sequences land well before expiry
    wr(`ADR_CTRL, 32'h39);
    step(60);
    wr(`ADR_KEY, 32'h55);
    wr(`ADR_KEY, 32'haa);
    bus(1'b0, `ADR_COUNT, 32'h0, rv);
    `CHK(rv < 32'h2, 1'b1)
    step(60);
    wr(`ADR_KEY, 32'h55);
    wr(`ADR_KEY, {24'h0, 8'h56 + 8'($urandom % 84)});
    wr(`ADR_KEY, 32'haa);
    bus(1'b0, `ADR_COUNT, 32'h0, rv);
    `CHK(rv > 32'h6, 1'b1)
    `WAITC(dog_interrupt_n_o === 1'b0, 2200)
    `CHK({dog_interrupt_n_o, dog_reset_out_n_o, device_reset_o}, 3'b010)
    n = 0;
    while (dog_interrupt_n_o === 1'b0 && n < 600)
    begin
      step(1);
      n++;
    end
    `CHK(n, 512)
    bus(1'b0, `ADR_STATUS, 32'h0, rv);
    `CHK(rv[2], 1'b1)
    wr(`ADR_CTRL, 32'h0b);
    `WAITC(dog_reset_out_n_o === 1'b0, 300)
    `CHK(dog_reset_out_n_o, 1'b0)
    wr(`ADR_CTRL, 32'h08);
    step(600);
    wr(`ADR_NMI_PERIOD, 32'h80);
    wr(`ADR_CTRL, 32'h39);
    input_clock_lost_i <= 1'b1;
    step(8);
    `CHK({limp_clock_sel_o, nmi_o}, 2'b11)
    bus(1'b0, `ADR_STATUS, 32'h0, rv);
    `CHK({rv[3], rv[1], rv[0]}, 3'b111)
    bus(1'b0, `ADR_COUNT, 32'h0, c0);
    step(40);
    bus(1'b0, `ADR_COUNT, 32'h0, rv);
    `CHK(rv, c0)
    `WAITC(device_reset_o === 1'b1, 200)
    `CHK({device_reset_o, dog_reset_out_n_o}, 2'b11)
    bus(1'b0, `ADR_COUNT, 32'h0, c0);
    bus(1'b0, `ADR_NMI_COUNT, 32'h0, rv);
    `CHK({c0, rv, nmi_o}, 65'h0)
    input_clock_lost_i <= 1'b0;
    step(600);
    wr(`ADR_CTRL, 32'h0c);
    input_clock_lost_i <= 1'b1;
    `WAITC(device_reset_o === 1'b1, 10)
    `CHK(device_reset_o, 1'b1)
    input_clock_lost_i <= 1'b0;
    step(600);
    wr(`ADR_STATUS, 32'h7);
    wr(`ADR_LPC, 32'h200);
    wr(`ADR_CTRL, 32'h09);
    sleep();
    `CHK(clock_gate_o, gates(2'b00))
    `WAITC(dog_irq_to_expander_o === 1'b1, 300)
    `CHK({dog_irq_to_expander_o, low_power_o}, 2'b11)
    cpu_irq_i <= 1'b1;
    step(2);
    cpu_irq_i <= 1'b0;
    `CHK(low_power_o, 1'b0)
    wr(`ADR_CTRL, 32'h08);
    step(600);
    wr(`ADR_WAKE_SEL, 32'h1 << sel_line);
    wr(`ADR_CTRL, 32'h79);
    wr(`ADR_KEY, 32'h55);
    wr(`ADR_KEY, 32'haa);
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADR_LPC, {16'h0, 8'h04, 6'h0, md[i]});
      sleep();
      `CHK(clock_gate_o, gates(md[i]))
      `CHK(pin_hold_o, 1'b1)
      pull(1, 20);
      pull(src[i], 2);
      `CHK(low_power_o, 1'b1)
      pull(src[i], 12);
      `WAITC(low_power_o === 1'b0, 10)
      `CHK(low_power_o, 1'b0)
    end
    wr(`ADR_CTRL, 32'h71);
    wr(`ADR_LPC, 32'h402);
    sleep();
    `CHK(low_power_o, 1'b0)
    wr(`ADR_CTRL, 32'h09);
    wr(`ADR_LPC, 32'h401);
    sleep();
    `WAITC(low_power_o === 1'b0, 400)
    `CHK({low_power_o, dog_interrupt_n_o}, 2'b00)
    wr(`ADR_CTRL, 32'h08);
    step(600);
    wr(`ADR_LPC, 32'h402);
    wr(`ADR_CTRL, 32'h0b);
    sleep();
    `WAITC(device_reset_o === 1'b1, 400)
    step(2);
    `CHK({device_reset_o, low_power_o}, 2'b10)
    close_out();
  end
endmodule : testbench

/* tb/wake_pin_model.sv */
`timescale 1ns/1ps
module wake_pin_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [4:0] line_i,
  input wire logic [7:0] hold_i,
  output logic [31:0] gpio_a_o
);
  logic [7:0] left_q;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      left_q <= 8'h00;
    else if (go_i && left_q == 8'h00)
      left_q <= hold_i;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // Pull-ups keep idle lines high; a hold shorter than the qualification leaves the device asleep
  always_comb
  begin
    gpio_a_o = 32'hffff_ffff;
    if (left_q != 8'h00)
      gpio_a_o[line_i] = 1'b0;
  end
endmodule : wake_pin_model
